// [chan_cfg_mem.sv]
// Per-channel gain and offset store with one registered read port
module chan_cfg_mem
    import quad_dac_pkg::*;
#(
    parameter int DEPTH = NUM_CHAN
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               reset_n,
    // Write side
    input  wire logic [DEPTH-1:0]   wr_mask,
    input  wire field_type          wr_field,
    input  wire logic [15:0]        wr_data,
    // Read side
    input  wire logic [1:0]         rd_addr,
    output      chan_cfg_type       rd_data_q
);

    // =====================================================================
    // Storage
    // =====================================================================
    chan_cfg_type mem_q [DEPTH];      // One entry per channel
    chan_cfg_type mem_d [DEPTH];      // Next entry values
    chan_cfg_type rd_data_d;          // Next read data

    // Only the addressed field of an entry changes
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_entry
            always_comb begin
                mem_d[i] = mem_q[i];
                if (wr_mask[i]) begin
                    case (wr_field)
                        FLD_CGAIN: mem_d[i].cgain = wr_data[1:0];
                        FLD_FGAIN: mem_d[i].fgain = wr_data[5:0];
                        FLD_OFFS:  mem_d[i].offs  = wr_data[7:0];
                        default:   mem_d[i] = mem_q[i];
                    endcase
                end
            end

            // Entries reset to no adjustment, default range
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    mem_q[i] <= '0;
                end else begin
                    mem_q[i] <= mem_d[i];
                end
            end
        end
    endgenerate

    // Read data comes out of a register
    always_comb begin
        rd_data_d = mem_q[rd_addr];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

endmodule

// [quad_dac_command_update_ctrl.sv]
// Command decode and output update of a four channel converter
//
// Function
// - Strobe high in frame: update all on fall
// - Strobe low in frame: update at frame end
// - Offset binary or twos complement channel codes
// - Coding select low twos, high offset binary
// - Clear falling edge forces outputs to clear
// - Outputs stay cleared until new update
// - Clear low at power-on loads clear value
// - Upper byte 0x04 is a software clear
// - Word: rw, zero, register, channel, data
// - Register select decodes five registers
// - Channel address decodes A-D and all
// - Read flag chooses read or write
// - Only exactly 24 falling edges accepted
// - Read data shifts out next frame
module quad_dac_command_update_ctrl
    import quad_dac_pkg::*;
#(
    parameter int CLEAR_CYCLES = CLEAR_MIN_CYCLES  // Least qualified clear low
) (
    // System clock and reset
    input  wire logic               clk,
    input  wire logic               reset_n,
    // Serial link, own clock
    input  wire logic               serial_clk,
    input  wire logic               frame_sel_n,
    input  wire logic               serial_in,
    output      logic               serial_out,
    output      logic               serial_out_oe,
    // Control pins
    input  wire logic               update_strobe_n,
    input  wire logic               async_clear_n,
    input  wire logic               coding_select,
    // Channel output codes, offset binary
    output      logic [3:0][15:0]   out_code
);

    // =====================================================================
    // Link side: shift in on falling serial clock edges
    // =====================================================================
    logic [23:0]  shift_q;            // Input shift register
    logic [23:0]  shift_d;
    logic [4:0]   edge_cnt_q;         // Falling edges in this frame
    logic [4:0]   edge_cnt_d;
    logic [4:0]   rise_cnt_q;         // Rising edges in this frame
    logic [4:0]   rise_cnt_d;
    logic         sdo_q;              // Serial out bit
    logic         sdo_d;
    logic         sdo_oe_q;           // Serial out driven
    logic         sdo_dis_q;          // Serial out disable, system side
    cmd_word_type cap_word_q;         // Word latched at frame end
    logic         cap_ok_q;           // Latched word had 24 edges

    // Next shift and edge count; count parks so overlong frames fail
    always_comb begin
        shift_d    = {shift_q[22:0], serial_in};
        edge_cnt_d = (edge_cnt_q == EDGE_SAT) ? edge_cnt_q : edge_cnt_q + 5'h01;
    end

    // Data register needs no reset; only the count qualifies it
    always_ff @(negedge serial_clk) begin
        if (!frame_sel_n) begin
            shift_q <= shift_d;
        end
    end

    // Count restarts while frame select is high
    always_ff @(negedge serial_clk or posedge frame_sel_n or negedge reset_n) begin
        if (!reset_n) begin
            edge_cnt_q <= '0;
            sdo_oe_q   <= 1'b0;
        end else if (frame_sel_n) begin
            edge_cnt_q <= '0;
            sdo_oe_q   <= 1'b0;
        end else begin
            edge_cnt_q <= edge_cnt_d;
            sdo_oe_q   <= ~sdo_dis_q;
        end
    end

    // Frame end latch; count sampled before its own clear lands
    always_ff @(posedge frame_sel_n or negedge reset_n) begin
        if (!reset_n) begin
            cap_word_q <= '0;
            cap_ok_q   <= 1'b0;
        end else begin
            cap_word_q <= shift_q;
            cap_ok_q   <= (edge_cnt_q == FRAME_EDGES);
        end
    end

    // =====================================================================
    // Link side: readback out on rising edges
    // =====================================================================
    logic [23:0] rb_word_q;           // Readback word, held stable in frames

    always_comb begin
        rise_cnt_d = (rise_cnt_q == EDGE_SAT) ? rise_cnt_q : rise_cnt_q + 5'h01;
        sdo_d      = 1'b0;
        if (rise_cnt_q <= LAST_OUT) begin
            sdo_d = rb_word_q[LAST_OUT - rise_cnt_q];
        end
    end

    // Frame select high parks the output low; bit 23 is always zero
    always_ff @(posedge serial_clk or posedge frame_sel_n or negedge reset_n) begin
        if (!reset_n) begin
            rise_cnt_q <= '0;
            sdo_q      <= 1'b0;
        end else if (frame_sel_n) begin
            rise_cnt_q <= '0;
            sdo_q      <= 1'b0;
        end else begin
            rise_cnt_q <= rise_cnt_d;
            sdo_q      <= sdo_d;
        end
    end

    assign serial_out    = sdo_q;
    assign serial_out_oe = sdo_oe_q;

    // =====================================================================
    // System side: pin synchronisers
    // =====================================================================
    logic [1:0] fs_sync_q;            // Frame select, two flops
    logic       fs_prev_q;            // Edge history
    logic [1:0] ld_sync_q;            // Update strobe
    logic       ld_prev_q;
    logic [1:0] clr_sync_q;           // Clear input
    logic [1:0] cod_sync_q;           // Coding select

    // Idle levels at reset: a clear held low at power-on is seen as a fall
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fs_sync_q  <= 2'h3;
            fs_prev_q  <= 1'b1;
            ld_sync_q  <= 2'h3;
            ld_prev_q  <= 1'b1;
            clr_sync_q <= 2'h3;
            cod_sync_q <= 2'h0;
        end else begin
            fs_sync_q  <= {fs_sync_q[0], frame_sel_n};
            fs_prev_q  <= fs_sync_q[1];
            ld_sync_q  <= {ld_sync_q[0], update_strobe_n};
            ld_prev_q  <= ld_sync_q[1];
            clr_sync_q <= {clr_sync_q[0], async_clear_n};
            cod_sync_q <= {cod_sync_q[0], coding_select};
        end
    end

    // =====================================================================
    // System side: command decode, update and clear
    // =====================================================================
    logic [3:0][15:0] data_q;         // Channel data registers, raw code
    logic [3:0][15:0] data_d;
    logic [3:0][15:0] out_d;
    logic             sdo_dis_d;      // Next serial out disable
    logic [23:0]      rb_word_d;
    rb_state_type     rb_state_q;     // Readback fetch
    rb_state_type     rb_state_d;
    cmd_word_type     rb_cmd_q;       // Read request being served
    cmd_word_type     rb_cmd_d;
    logic [7:0]       clr_cnt_q;      // Clear low duration
    logic [7:0]       clr_cnt_d;
    logic             frame_end;
    logic             strobe_fall;
    logic             clr_fire;
    logic             twos;
    logic [3:0]       upd_mask;
    logic [3:0]       cfg_mask;
    logic [3:0]       wr_mask;
    field_type        cfg_field;
    chan_cfg_type     cfg_rd;
    cmd_word_type     cmd;

    assign frame_end   = fs_sync_q[1] & ~fs_prev_q;
    assign strobe_fall = ld_prev_q & ~ld_sync_q[1];
    assign twos        = ~cod_sync_q[1];
    assign cmd         = cap_word_q;

    // Per-channel gain and offset store
    chan_cfg_mem #(
        .DEPTH     (NUM_CHAN)
    ) u_cfg (
        .clk       (clk),
        .reset_n   (reset_n),
        .wr_mask   (cfg_mask),
        .wr_field  (cfg_field),
        .wr_data   (cmd.data),
        .rd_addr   (cmd.channel_address[1:0]),
        .rd_data_q (cfg_rd)
    );

    // Next state of all system side control
    always_comb begin
        data_d     = data_q;
        out_d      = out_code;
        sdo_dis_d  = sdo_dis_q;
        rb_word_d  = rb_word_q;
        rb_state_d = rb_state_q;
        rb_cmd_d   = rb_cmd_q;
        upd_mask   = 4'h0;
        cfg_mask   = 4'h0;
        cfg_field  = FLD_CGAIN;
        wr_mask    = chan_mask(cmd.channel_address);
        clr_cnt_d  = clr_cnt_q;
        clr_fire   = 1'b0;

        // Clear acts once it has stayed low long enough
        if (clr_sync_q[1]) begin
            clr_cnt_d = 8'h00;
        end else if (clr_cnt_q != 8'(CLEAR_CYCLES)) begin
            clr_cnt_d = clr_cnt_q + 8'h01;
            clr_fire  = (clr_cnt_q == 8'(CLEAR_CYCLES - 1));
        end

        // Decode only frames of exactly 24 edges
        if (frame_end && cap_ok_q) begin
            if (cmd.rw) begin
                rb_cmd_d   = cmd;
                rb_state_d = RB_FETCH;
            end else begin
                case (cmd.register_select)
                    REG_FUNC: begin
                        case (cmd.channel_address)
                            FN_CTRL:  sdo_dis_d = cmd.data[SDO_DIS_BIT];
                            FN_CLEAR: clr_fire  = 1'b1;
                            FN_LOAD:  upd_mask  = 4'hF;
                            default:  upd_mask  = 4'h0;
                        endcase
                    end
                    REG_DATA: begin
                        for (int i = 0; i < NUM_CHAN; i++) begin
                            if (wr_mask[i]) begin
                                data_d[i] = cmd.data;
                            end
                        end
                        // Strobe low: load at frame end
                        if (!ld_sync_q[1]) begin
                            upd_mask = wr_mask;
                        end
                    end
                    REG_CGAIN: begin
                        cfg_mask  = wr_mask;
                        cfg_field = FLD_CGAIN;
                    end
                    REG_FGAIN: begin
                        cfg_mask  = wr_mask;
                        cfg_field = FLD_FGAIN;
                    end
                    REG_OFFS: begin
                        cfg_mask  = wr_mask;
                        cfg_field = FLD_OFFS;
                    end
                    default: cfg_mask = 4'h0;
                endcase
            end
        end

        // Strobe fall loads every channel
        if (strobe_fall) begin
            upd_mask = 4'hF;
        end

        for (int i = 0; i < NUM_CHAN; i++) begin
            if (upd_mask[i]) begin
                out_d[i] = to_out(data_d[i], twos);
            end
        end

        // Clear wins; data also cleared so later loads keep the value
        if (clr_fire) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                data_d[i] = CLEAR_RAW;
                out_d[i]  = to_out(CLEAR_RAW, twos);
            end
        end

        // Readback word one cycle after the store's read port settles
        case (rb_state_q)
            RB_IDLE: rb_state_d = rb_state_d;
            RB_FETCH: begin
                rb_state_d = RB_IDLE;
                rb_word_d  = {2'h0, rb_cmd_q.register_select,
                              rb_cmd_q.channel_address, 16'h0000};
                case (rb_cmd_q.register_select)
                    REG_FUNC:  rb_word_d[SDO_DIS_BIT] = sdo_dis_q;
                    REG_DATA:  rb_word_d[15:0] = data_q[rb_cmd_q.channel_address[1:0]];
                    REG_CGAIN: rb_word_d[1:0]  = cfg_rd.cgain;
                    REG_FGAIN: rb_word_d[5:0]  = cfg_rd.fgain;
                    REG_OFFS:  rb_word_d[7:0]  = cfg_rd.offs;
                    default:   rb_word_d[15:0] = 16'h0000;
                endcase
            end
            default: rb_state_d = RB_IDLE;
        endcase
    end

    // System side registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_q     <= {NUM_CHAN{RESET_RAW}};
            out_code   <= {NUM_CHAN{OUT_RESET}};
            sdo_dis_q  <= 1'b0;
            rb_word_q  <= '0;
            rb_state_q <= RB_IDLE;
            rb_cmd_q   <= '0;
            clr_cnt_q  <= 8'h00;
        end else begin
            data_q     <= data_d;
            out_code   <= out_d;
            sdo_dis_q  <= sdo_dis_d;
            rb_word_q  <= rb_word_d;
            rb_state_q <= rb_state_d;
            rb_cmd_q   <= rb_cmd_d;
            clr_cnt_q  <= clr_cnt_d;
        end
    end

endmodule

// [quad_dac_command_update_ctrl_props.sv]
// Port checker of the converter control
module quad_dac_ctrl_props
    import quad_dac_pkg::*;
#(
    parameter int CLEAR_CYCLES = 1  // Qualified clear low length
) (
    // System clock and reset
    input wire logic             clk,
    input wire logic             reset_n,
    // Serial link
    input wire logic             serial_clk,
    input wire logic             frame_sel_n,
    input wire logic             serial_in,
    input wire logic             serial_out,
    input wire logic             serial_out_oe,
    // Control pins and outputs
    input wire logic             update_strobe_n,
    input wire logic             async_clear_n,
    input wire logic             coding_select,
    input wire logic [3:0][15:0] out_code
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic [4:0]  edges_q;  // Link edges in frame
    logic [23:0] word_q;   // Bits shifted in
    logic [4:0]  seen_q;   // Edge count on clk
    logic [15:0] clr;      // Clear output code
    logic [15:0] want;     // Code of a data write
    logic [1:0]  slot;     // Output it touches

    // Counts in frames; parks so long frames never wrap
    always_ff @(negedge serial_clk or posedge frame_sel_n) begin
        if (frame_sel_n) begin
            edges_q <= 5'h00;
        end else begin
            edges_q <= (edges_q == 5'h1F) ? edges_q : edges_q + 5'h01;
            word_q  <= {word_q[22:0], serial_in};
        end
    end

    // Last count before the frame ends
    always_ff @(posedge clk) begin
        if (!frame_sel_n) begin
            seen_q <= edges_q;
        end
    end

    assign clr  = coding_select ? 16'h0000 : 16'h8000;
    assign want = coding_select ? word_q[15:0] : {~word_q[15], word_q[14:0]};
    assign slot = (word_q[18:16] == CHAN_ALL) ? 2'h0 : word_q[17:16];

    sequence frame_ok;
        $rose(frame_sel_n) && seen_q == FRAME_EDGES && async_clear_n;
    endsequence
    sequence outs_hold;
        ##1 $stable(out_code) [*6];
    endsequence

    AST_PWR: assert property (!$past(reset_n) && !async_clear_n |-> ##[1:8] out_code == {4{clr}})
        else $error("no power-on clear");
    AST_CLR: assert property (!async_clear_n [*6] |-> out_code == {4{clr}})
        else $error("no clear value");
    AST_KEEP: assert property ($rose(async_clear_n) |-> $stable(out_code) [*4])
        else $error("outputs moved after clear");
    AST_INDIV: assert property (frame_ok ##0 (!update_strobe_n && word_q[23:19] == {2'b00, REG_DATA}
        && word_q[18:16] <= CHAN_ALL) |-> ##5 out_code[slot] == want)
        else $error("individual update wrong");
    AST_SWCLR: assert property (frame_ok ##0 (word_q[23:16] == 8'h04) |-> ##5 out_code == {4{clr}})
        else $error("software clear wrong");
    AST_DISCARD: assert property ($rose(frame_sel_n) && async_clear_n && (seen_q != FRAME_EDGES
        || word_q[21:19] inside {3'h1, 3'h6, 3'h7} || word_q[18:16] > CHAN_ALL) |-> outs_hold)
        else $error("refused frame acted");
    AST_DEFER: assert property ($rose(frame_sel_n) && update_strobe_n && async_clear_n
        && word_q[21:19] != REG_FUNC |-> outs_hold)
        else $error("update without strobe fall");
    AST_IDLE: assert property (frame_sel_n [*2] |-> !serial_out_oe && !serial_out)
        else $error("serial out driven idle");
endmodule

bind quad_dac_command_update_ctrl quad_dac_ctrl_props #(.CLEAR_CYCLES(CLEAR_CYCLES)) props (
    .clk(clk), .reset_n(reset_n), .serial_clk(serial_clk), .frame_sel_n(frame_sel_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .update_strobe_n(update_strobe_n), .async_clear_n(async_clear_n),
    .coding_select(coding_select), .out_code(out_code));

// [quad_dac_host_model.sv]
// Host end of the serial link
module quad_dac_host_model (
    // Link pins
    output logic      serial_clk,
    output logic      frame_sel_n,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    logic line_q = 1'b0;  // Readback line level

    // Link clock parked high between frames
    initial begin
        serial_clk  = 1'b1;
        frame_sel_n = 1'b1;
        serial_in   = 1'b0;
    end

    // Frame of n falling edges, MSB first
    task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rd);
        rd = 24'h000000;
        #7;
        frame_sel_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_in = w[23 - (i % 24)];
            #12;
            serial_clk = 1'b0;
            #1;
            // Undriven line has no pull, so it shows the inverse
            line_q = serial_out_oe ? serial_out : ~line_q;
            rd = {rd[22:0], line_q};
            #23;
            serial_clk = 1'b1;
            #12;
        end
        #12;
        frame_sel_n = 1'b1;
        serial_in = ~serial_in;
    endtask
endmodule

// [quad_dac_pkg.sv]
// Constants, types and helpers of the converter control
package quad_dac_pkg;

    // =====================================================================
    // Sizes
    // =====================================================================
    localparam int WORD_BITS = 24;            // Serial command word length
    localparam int DATA_BITS = 16;            // Channel code width
    localparam int NUM_CHAN  = 4;             // Channels A to D

    // =====================================================================
    // Command word field codes
    // =====================================================================
    localparam logic [2:0] REG_FUNC  = 3'h0;  // Function register
    localparam logic [2:0] REG_DATA  = 3'h2;  // Data register
    localparam logic [2:0] REG_CGAIN = 3'h3;  // Coarse gain register
    localparam logic [2:0] REG_FGAIN = 3'h4;  // Fine gain register
    localparam logic [2:0] REG_OFFS  = 3'h5;  // Offset register
    localparam logic [2:0] CHAN_ALL  = 3'h4;  // All four channels at once
    localparam logic [2:0] FN_NOP    = 3'h0;  // No-operation command
    localparam logic [2:0] FN_CTRL   = 3'h1;  // Control bits (serial out disable)
    localparam logic [2:0] FN_CLEAR  = 3'h4;  // Software clear
    localparam logic [2:0] FN_LOAD   = 3'h5;  // Load all outputs
    localparam int         SDO_DIS_BIT = 0;   // Serial out disable bit position

    // =====================================================================
    // Frame counting
    // =====================================================================
    localparam logic [4:0] FRAME_EDGES = 5'h18; // Exactly 24 falling edges
    localparam logic [4:0] EDGE_SAT    = 5'h19; // Counter parks above 24
    localparam logic [4:0] LAST_OUT    = 5'h16; // Last readback bit index

    // =====================================================================
    // Codes and reset values
    // =====================================================================
    localparam logic [15:0] RESET_RAW  = 16'h0000; // Data registers at reset
    localparam logic [15:0] CLEAR_RAW  = 16'h0000; // Raw code after a clear
    localparam logic [15:0] OUT_RESET  = 16'h8000; // Output code 0 V at reset
    localparam logic [15:0] MSB_FLIP   = 16'h8000; // Twos comp to offset binary

    // =====================================================================
    // Timing
    // =====================================================================
    localparam int CLK_PERIOD_NS    = 25;     // 40 MHz system clock
    localparam int CLEAR_MIN_LOW_NS = 20;     // Least clear low time
    localparam int CLEAR_MIN_CYCLES =
        ((CLEAR_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
        ((CLEAR_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // =====================================================================
    // Types
    // =====================================================================
    typedef struct packed {
        logic        rw;                      // 1 = read request
        logic        zero;                    // Must be zero; decode does not check it
        logic [2:0]  register_select;
        logic [2:0]  channel_address;
        logic [15:0] data;
    } cmd_word_type;

    typedef struct packed {
        logic [7:0] offs;                     // Offset adjust
        logic [5:0] fgain;                    // Fine gain adjust
        logic [1:0] cgain;                    // Coarse gain range
    } chan_cfg_type;

    typedef enum logic [1:0] {FLD_CGAIN, FLD_FGAIN, FLD_OFFS} field_type;

    typedef enum logic {RB_IDLE, RB_FETCH} rb_state_type;

    // Channel address to write mask; unlisted codes give none
    function automatic logic [3:0] chan_mask(input logic [2:0] addr);
        logic [3:0] m;
        m = 4'h0;
        if (addr == CHAN_ALL) begin
            m = 4'hF;
        end else if (addr < CHAN_ALL) begin
            m = 4'h1 << addr[1:0];
        end
        return m;
    endfunction

    // Raw code to offset binary output code
    function automatic logic [15:0] to_out(input logic [15:0] raw, input logic twos);
        return twos ? (raw ^ MSB_FLIP) : raw;
    endfunction

endpackage

// [test_quad_dac_command_update_ctrl.sv]
// Self-checking bench of the converter control
module test_quad_dac_command_update_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    import quad_dac_pkg::*;
    `define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end

    localparam int CLRC = 2;  // Short clear
    logic             clk = 0, reset_n = 0, update_strobe_n = 1, async_clear_n = 0;
    logic             coding_select = 1;
    logic             serial_clk, frame_sel_n, serial_in, serial_out, serial_out_oe;
    logic [3:0][15:0] out_code;
    logic [15:0]      raw [4];    // Data register copy
    logic [15:0]      exp_q [4];  // Expected output codes
    logic [23:0]      rd;         // Last readback word
    int               errors = 0, compares = 0, seed = 82937;
    logic [15:0]      corner [4] = '{16'h0000, 16'h8000, 16'h7FFF, 16'hFFFF};
    logic [23:0]      bad [7] = '{24'h101234, 24'h105678, 24'h15ABCD, 24'h17ABCD,
                                  24'h0A1111, 24'h321111, 24'h3A1111};
    logic [2:0]       rsel [4] = '{REG_CGAIN, REG_FGAIN, REG_OFFS, REG_DATA};
    logic [15:0]      rmask [4] = '{16'h0003, 16'h003F, 16'h00FF, 16'hFFFF};

    quad_dac_command_update_ctrl #(.CLEAR_CYCLES(CLRC)) DUT (
        .clk(clk), .reset_n(reset_n), .serial_clk(serial_clk), .frame_sel_n(frame_sel_n),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .update_strobe_n(update_strobe_n), .async_clear_n(async_clear_n),
        .coding_select(coding_select), .out_code(out_code));
    quad_dac_host_model host (.serial_clk(serial_clk), .frame_sel_n(frame_sel_n),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

    // 40 MHz system clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // Output code of a raw value
    function automatic logic [15:0] code_of(input logic [15:0] d, input logic cs);
        return cs ? d : {~d[15], d[14:0]};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // Frame, then decode settle time
    task automatic send(input logic [23:0] w, input int n);
        host.xfer(w, n, rd);
        tick(8);
    endtask
    task automatic chk_all();
        for (int c = 0; c < 4; c++) `CHK(out_code[c], exp_q[c])
    endtask
    task automatic clear_exp();
        for (int c = 0; c < 4; c++) begin
            raw[c] = 16'h0000;
            exp_q[c] = code_of(16'h0000, coding_select);
        end
    endtask
    // Data write; outputs follow if strobe low
    task automatic wr_data(input logic [2:0] ch, input logic [15:0] d);
        send({2'b00, REG_DATA, ch, d}, 24);
        for (int c = 0; c < 4; c++) begin
            if (ch == CHAN_ALL || ch == 3'(c)) begin
                raw[c] = d;
                if (!update_strobe_n) exp_q[c] = code_of(d, coding_select);
            end
        end
    endtask
    task automatic end_of_test();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #500_000;
        errors++;
        end_of_test();
    end

    initial begin
        logic [15:0] v;
        // Clear low through reset, offset binary
        tick(20);
        reset_n = 1;
        tick(CLRC + 6);
        clear_exp();
        chk_all();
        async_clear_n = 1;
        update_strobe_n = 0;
        tick(6);
        chk_all();
        // Corner codes, then random updates
        for (int i = 0; i < 16; i++) begin
            coding_select = 1'($random(seed));
            tick(6);
            wr_data(i < 5 ? 3'(i) : 3'($unsigned($random(seed)) % 5),
                    i < 4 ? corner[i] : 16'($random(seed)));
            chk_all();
        end
        // Refused frames change nothing
        foreach (bad[k]) begin
            send(bad[k], k < 2 ? 23 + 2 * k : 24);
            chk_all();
        end
        // Deferred writes, one strobe fall
        update_strobe_n = 1;
        tick(2);
        wr_data(3'h2, 16'h1357);
        chk_all();
        wr_data(3'h0, 16'hFFFF);
        update_strobe_n = 0;
        tick(6);
        for (int c = 0; c < 4; c++) exp_q[c] = code_of(raw[c], coding_select);
        chk_all();
        // Write, read request, idle frame reads
        for (int k = 0; k < 4; k++) begin
            v = 16'($random(seed)) & rmask[k];
            send({2'b00, rsel[k], 3'h1, v}, 24);
            if (rsel[k] == REG_DATA) begin
                raw[1] = v;
                exp_q[1] = code_of(v, coding_select);
            end
            send({2'b10, rsel[k], 3'h1, 16'hFFFF}, 24);
            send(24'h000000, 24);
            `CHK(rd, {2'b00, rsel[k], 3'h1, v})
        end
        chk_all();
        // Software clear in twos complement coding
        coding_select = 0;
        tick(6);
        send(24'h04BEEF, 24);
        clear_exp();
        chk_all();
        // Pin clear mid-run
        wr_data(CHAN_ALL, 16'h1234);
        coding_select = 1;
        tick(6);
        async_clear_n = 0;
        tick(CLRC + 5);
        async_clear_n = 1;
        tick(4);
        clear_exp();
        chk_all();
        end_of_test();
    end
endmodule
